// ### shared/cgscp_params.svh
// Purpose: Offsets, field positions, reset values and timing counts of the clock generator config port.
// Assumes: 100 MHz system clock.
// Notes: Included by the port design file only.
`ifndef CGSCP_PARAMS_SVH
`define CGSCP_PARAMS_SVH
`define CGSCP_ADDR7 7'h69
`define CGSCP_OFS_FUNC_FREQ 4'h0
`define CGSCP_OFS_PROC_CLK 4'h1
`define CGSCP_FUNC_FREQ_RST 8'h42
`define CGSCP_PROC_CLK_RST 8'hff
`define CGSCP_COUNT_RST 8'h09
`define CGSCP_NUM_BYTES 2
`define CGSCP_B0_SEL_SRC 3
`define CGSCP_B0_FS4 2
`define CGSCP_B0_SPREAD 1
`define CGSCP_B0_TRISTATE 0
`define CGSCP_B1_MEM_DRIVE 6
`define CGSCP_B1_PP_DRIVE 5
`define CGSCP_B1_DIFF_DRIVE 4
`define CGSCP_B1_FREE_RUN_EN 3
`define CGSCP_B1_DIFF_EN 1
`define CGSCP_B1_PP_EN 0
`define CGSCP_BIT_RATE_KBPS 100
`define CGSCP_CLK_MHZ 100
`define CGSCP_STRAP_SETTLE_NS 1000
`define CGSCP_STRAP_SETTLE_CYC ((`CGSCP_STRAP_SETTLE_NS * `CGSCP_CLK_MHZ + 999) / 1000)
`endif

// ### shared/cgscp_pkg.sv
// Purpose: Types of the clock generator config port.
// Assumes: Constants come from cgscp_params.svh.
// Notes: One-hot state codes.
package cgscp_pkg;
   typedef enum logic [6:0] {
      CGSCP_IDLE = 7'h01,
      CGSCP_ADDR = 7'h02,
      CGSCP_CMD = 7'h04,
      CGSCP_CNT = 7'h08,
      CGSCP_WDATA = 7'h10,
      CGSCP_RDATA = 7'h20,
      CGSCP_IGNORE = 7'h40
   } cgscp_state_t;
endpackage

// ### hdl/cgscp_sync.sv
// Purpose: Two flip-flop synchroniser for pin inputs.
// Assumes: Asynchronous active-low reset.
// Notes: The first stage is read only by the second.
`timescale 1ns/1ps
module cgscp_sync #(
   parameter int WIDTH = 1,
   parameter logic [WIDTH-1:0] RST_VAL = '0
) (
   input wire logic clock,
   input wire logic resetn,
   input wire logic [WIDTH-1:0] async_in,
   output logic [WIDTH-1:0] sync_out
);
   typedef struct packed {
      logic [WIDTH-1:0] meta;
      logic [WIDTH-1:0] sync;
   } cgscp_sync_st_t;
   cgscp_sync_st_t s_q, s_d;
   always_comb begin
      s_d.meta = async_in;
      s_d.sync = s_q.meta;
   end
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         s_q <= {RST_VAL, RST_VAL};
      end else begin
         s_q <= s_d;
      end
   end
   assign sync_out = s_q.sync;
endmodule // cgscp_sync

// ### hdl/cgscp_port.sv
// Purpose: Two-wire slave configuration port with control bytes 0 and 1.
// Assumes: Bus bit rate far below the 100 MHz clock; SDA and SCL sampled through two flip-flops.
// Notes: Reads return the count byte then control bytes; out-of-range bytes read as zero.
//
// Contract
// R1 - Answer only write 0xD2 and read 0xD3.
// R2 - Slave accepts writes and returns reads.
// R3 - Standard mode 100 kbit/s bit rate.
// R4 - Bits shift most significant first.
// R5 - Ascending byte order, pointer advances per byte.
// R6 - Receiver acknowledges every byte.
// R7 - Missing acknowledge ends the transfer.
// R8 - Write: command and count acknowledged, discarded.
// R9 - Read: count byte first, then data.
// R10 - Count byte resets to nine.
// R11 - Byte 0 holds five-bit frequency code.
// R12 - Byte 0 bit 3 picks register or straps.
// R13 - Byte 0 bit 1 enables spread spectrum.
// R14 - Byte 0 bit 0 tristates all outputs.
// R15 - Byte 1 bit 6 memory clock strength.
// R16 - Bits 5, 4 processor clock strengths.
// R17 - Byte 1 bit 3 gates free-running memory clock.
// R18 - Bits 1, 0 enable processor clocks.
// R19 - Straps sampled at power-up, then outputs.
// R20 - Foreign addresses ignored, bus left undriven.
`timescale 1ns/1ps
`include "cgscp_params.svh"
module cgscp_port #(
   parameter int STRAP_SETTLE_CYC = `CGSCP_STRAP_SETTLE_CYC
) (
   input wire logic clock,
   input wire logic resetn,
   input wire logic scl_in,
   input wire logic sda_in,
   output logic sda_out,
   output logic sda_oe,
   input wire logic [3:0] strap_freq_code,
   output logic strap_phase,
   output logic [4:0] freq_code,
   output logic spread_enable,
   output logic outputs_tristate,
   output logic memory_drive_normal,
   output logic host_pushpull_drive_normal,
   output logic host_diff_drive_normal,
   output logic memory_clock_free_run_enable,
   output logic host_diff_clock_enable,
   output logic host_pushpull_clock_enable
);
   import cgscp_pkg::*;

   ////////////////////////////////////////////////////////////////////////////
   typedef struct packed {
      cgscp_state_t st;
      logic scl_p;
      logic sda_p;
      logic [7:0] shift;
      logic [3:0] bitcnt;
      logic ack_phase;
      logic master_ack;
      logic [3:0] ptr;
      logic [7:0] func_freq;
      logic [7:0] proc_clk;
      logic [3:0] strap_lat;
      logic strap_done;
      logic [15:0] settle;
      logic sda_drv;
      logic sda_o;
   } cgscp_port_st_t;
   cgscp_port_st_t s_q, s_d;
   logic scl_s, sda_s;
   logic [3:0] strap_s;
   logic scl_rise, scl_fall, start_c, stop_c;

   cgscp_sync #(.WIDTH(2), .RST_VAL(2'h3)) u_bus_sync ( // R3
      .clock(clock),
      .resetn(resetn),
      .async_in({scl_in, sda_in}),
      .sync_out({scl_s, sda_s})
   );
   cgscp_sync #(.WIDTH(4), .RST_VAL(4'h0)) u_strap_sync (
      .clock(clock),
      .resetn(resetn),
      .async_in(strap_freq_code),
      .sync_out(strap_s)
   );

   // Read source: index 0 is the count byte, then control bytes from 0 up.
   function automatic logic [7:0] rd_byte(input logic [3:0] idx, input logic [7:0] b0, input logic [7:0] b1);
      if (idx == 4'h0) begin
         rd_byte = `CGSCP_COUNT_RST; // R9 R10
      end else if (idx - 4'h1 == `CGSCP_OFS_FUNC_FREQ) begin
         rd_byte = b0;
      end else if (idx - 4'h1 == `CGSCP_OFS_PROC_CLK) begin
         rd_byte = b1;
      end else begin
         rd_byte = 8'h00;
      end
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // The bit rate limit (R3) is left to the master; oversampling at 100 MHz covers it with wide margin.
   assign scl_rise = scl_s && !s_q.scl_p;
   assign scl_fall = !scl_s && s_q.scl_p;
   assign start_c = scl_s && s_q.scl_p && s_q.sda_p && !sda_s;
   assign stop_c = scl_s && s_q.scl_p && !s_q.sda_p && sda_s;

   always_comb begin
      s_d = s_q;
      s_d.scl_p = scl_s;
      s_d.sda_p = sda_s;
      // Straps are held until the settle count expires, then the pins become outputs.
      if (!s_q.strap_done) begin
         if (s_q.settle == 16'(STRAP_SETTLE_CYC - 1)) begin
            s_d.strap_done = 1'b1;
            s_d.strap_lat = strap_s; // R19
         end else begin
            s_d.settle = s_q.settle + 16'h0001;
         end
      end
      if (start_c) begin
         s_d.st = CGSCP_ADDR;
         s_d.bitcnt = 4'h0;
         s_d.ack_phase = 1'b0;
         s_d.sda_drv = 1'b0;
      end else if (stop_c) begin
         s_d.st = CGSCP_IDLE;
         s_d.sda_drv = 1'b0;
      end else if (scl_rise) begin
         if (s_q.ack_phase) begin
            s_d.master_ack = !sda_s; // R6
         end else if (s_q.st != CGSCP_IDLE && s_q.st != CGSCP_IGNORE) begin
            s_d.shift = {s_q.shift[6:0], sda_s}; // R4
            s_d.bitcnt = s_q.bitcnt + 4'h1;
         end
      end else if (scl_fall) begin
         case (s_q.st)
            CGSCP_IDLE, CGSCP_IGNORE: begin
               s_d.sda_drv = 1'b0;
            end
            CGSCP_RDATA: begin
               if (s_q.ack_phase) begin
                  s_d.ack_phase = 1'b0;
                  if (s_q.master_ack) begin
                     s_d.ptr = s_q.ptr + 4'h1; // R5
                     s_d.shift = rd_byte(s_q.ptr + 4'h1, s_q.func_freq, s_q.proc_clk);
                     s_d.sda_drv = 1'b1;
                     s_d.sda_o = s_d.shift[7]; // R4
                     s_d.bitcnt = 4'h0;
                  end else begin
                     s_d.st = CGSCP_IGNORE; // R7
                     s_d.sda_drv = 1'b0;
                  end
               end else if (s_q.bitcnt == 4'h8) begin
                  s_d.ack_phase = 1'b1;
                  s_d.sda_drv = 1'b0;
               end else begin
                  // The shifter refills from the bus on every data-bit rise, so the next bit to send is always on top.
                  s_d.sda_o = s_q.shift[7]; // R4
               end
            end
            default: begin
               if (s_q.ack_phase) begin
                  s_d.ack_phase = 1'b0;
                  s_d.sda_drv = 1'b0;
                  s_d.bitcnt = 4'h0;
                  if (s_q.st == CGSCP_ADDR && s_q.shift[0]) begin
                     // R2 R9
                     s_d.st = CGSCP_RDATA;
                     s_d.ptr = 4'h0;
                     s_d.shift = rd_byte(4'h0, s_q.func_freq, s_q.proc_clk);
                     s_d.sda_drv = 1'b1;
                     s_d.sda_o = s_d.shift[7]; // R4
                  end else if (s_q.st == CGSCP_ADDR) begin
                     s_d.st = CGSCP_CMD;
                  end else if (s_q.st == CGSCP_CMD) begin
                     s_d.st = CGSCP_CNT; // R8
                  end else if (s_q.st == CGSCP_CNT) begin
                     s_d.st = CGSCP_WDATA; // R8
                     s_d.ptr = 4'h0;
                  end else begin
                     s_d.ptr = s_q.ptr + 4'h1; // R5
                  end
               end else if (s_q.bitcnt == 4'h8) begin
                  if (s_q.st == CGSCP_ADDR && s_q.shift[7:1] != `CGSCP_ADDR7) begin
                     s_d.st = CGSCP_IGNORE; // R1 R20
                  end else begin
                     s_d.ack_phase = 1'b1;
                     s_d.sda_drv = 1'b1; // R6
                     s_d.sda_o = 1'b0;
                     if (s_q.st == CGSCP_WDATA) begin
                        if (s_q.ptr == `CGSCP_OFS_FUNC_FREQ) begin
                           s_d.func_freq = s_q.shift; // R11 R12 R13 R14
                        end else if (s_q.ptr == `CGSCP_OFS_PROC_CLK) begin
                           s_d.proc_clk = s_q.shift; // R15 R16 R17 R18
                        end
                     end
                  end
               end
            end
         endcase
      end
   end

   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         s_q.st <= CGSCP_IDLE;
         s_q.scl_p <= 1'b1;
         s_q.sda_p <= 1'b1;
         s_q.shift <= 8'h00;
         s_q.bitcnt <= 4'h0;
         s_q.ack_phase <= 1'b0;
         s_q.master_ack <= 1'b0;
         s_q.ptr <= 4'h0;
         s_q.func_freq <= `CGSCP_FUNC_FREQ_RST; // R11 R12 R13 R14
         s_q.proc_clk <= `CGSCP_PROC_CLK_RST; // R15 R16 R17 R18
         s_q.strap_lat <= 4'h0;
         s_q.strap_done <= 1'b0;
         s_q.settle <= 16'h0000;
         s_q.sda_drv <= 1'b0;
         s_q.sda_o <= 1'b1;
      end else begin
         s_q <= s_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Open drain: only a low is ever driven; the enable alone carries the level.
   assign sda_out = 1'b0;
   assign sda_oe = s_q.sda_drv && !s_q.sda_o;
   assign strap_phase = !s_q.strap_done;
   assign freq_code = s_q.func_freq[`CGSCP_B0_SEL_SRC] ?
      {s_q.func_freq[`CGSCP_B0_FS4], s_q.func_freq[7:4]} : {1'b0, s_q.strap_lat}; // R12
   assign spread_enable = s_q.func_freq[`CGSCP_B0_SPREAD]; // R13
   assign outputs_tristate = s_q.func_freq[`CGSCP_B0_TRISTATE]; // R14
   assign memory_drive_normal = s_q.proc_clk[`CGSCP_B1_MEM_DRIVE]; // R15
   assign host_pushpull_drive_normal = s_q.proc_clk[`CGSCP_B1_PP_DRIVE]; // R16
   assign host_diff_drive_normal = s_q.proc_clk[`CGSCP_B1_DIFF_DRIVE]; // R16
   assign memory_clock_free_run_enable = s_q.proc_clk[`CGSCP_B1_FREE_RUN_EN]; // R17
   assign host_diff_clock_enable = s_q.proc_clk[`CGSCP_B1_DIFF_EN]; // R18
   assign host_pushpull_clock_enable = s_q.proc_clk[`CGSCP_B1_PP_EN]; // R18
endmodule // cgscp_port

// ### test/cgscp_props.sv
// Purpose: Port assertions for the config port.
// Assumes: Bus far slower than clock.
// Notes: Bound below.
`timescale 1ns/1ps
module cgscp_props #(
   parameter int STRAP_SETTLE_CYC = 100
) (
   input wire logic clock,
   input wire logic resetn,
   input wire logic scl_in,
   input wire logic sda_out,
   input wire logic sda_oe,
   input wire logic [3:0] strap_freq_code,
   input wire logic strap_phase,
   input wire logic [4:0] freq_code,
   input wire logic spread_enable,
   input wire logic outputs_tristate,
   input wire logic memory_drive_normal,
   input wire logic host_diff_clock_enable
);
   logic [15:0] cnt_q;
   logic [15:0] cnt_d;
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!resetn);
   always_comb cnt_d = strap_phase ? cnt_q + 16'h0001 : cnt_q;
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         cnt_q <= 16'h0000;
      end else begin
         cnt_q <= cnt_d;
      end
   end
   chk_sda_drain: assert property (sda_out == 1'b0)
      else $error("sda driven high");
   chk_oe_rise: assert property ($rose(sda_oe) |-> !scl_in)
      else $error("sda taken in scl high");
   chk_oe_hold: assert property (scl_in && $past(scl_in, 4) |-> $stable(sda_oe))
      else $error("sda moved in scl high");
   chk_strap_once: assert property (!strap_phase |=> !strap_phase)
      else $error("strap phase again");
   chk_strap_len: assert property (cnt_q <= STRAP_SETTLE_CYC + 2)
      else $error("strap phase too long");
   chk_strap_zero: assert property (strap_phase |-> freq_code == 5'h00)
      else $error("code set in strap phase");
   chk_strap_latch: assert property ($fell(strap_phase) |-> ##[0:2] freq_code == {1'b0, strap_freq_code})
      else $error("straps not used");
   chk_cfg_low: assert property (!$stable({spread_enable, outputs_tristate, memory_drive_normal,
      host_diff_clock_enable}) |-> !scl_in)
      else $error("config moved in scl high");
   cov_ack: cover property ($rose(sda_oe));
   cov_strap: cover property ($fell(strap_phase));
   cov_tri: cover property ($rose(outputs_tristate));
endmodule // cgscp_props
bind cgscp_port cgscp_props #(.STRAP_SETTLE_CYC(STRAP_SETTLE_CYC)) u_props (.clock(clock), .resetn(resetn),
   .scl_in(scl_in), .sda_out(sda_out), .sda_oe(sda_oe), .strap_freq_code(strap_freq_code),
   .strap_phase(strap_phase), .freq_code(freq_code), .spread_enable(spread_enable),
   .outputs_tristate(outputs_tristate), .memory_drive_normal(memory_drive_normal),
   .host_diff_clock_enable(host_diff_clock_enable));

// ### test/cgscp_master.sv
// Purpose: Two-wire bus master model.
// Assumes: SDA has a pull-up.
// Notes: Tasks called by the bench.
`timescale 1ns/1ps
module cgscp_master (
   input wire logic clock,
   input wire logic sda,
   output logic scl,
   output logic sda_m
);
   // Four quarters make 10 us a bit, never above standard mode.
   localparam int Q = 250;
   initial begin
      scl = 1'b1;
      sda_m = 1'b1;
   end
   task automatic w();
      repeat (Q) @(posedge clock);
      #1;
   endtask
   task automatic start();
      sda_m = 1'b0;
      w();
      scl = 1'b0;
      w();
   endtask
   task automatic stop();
      sda_m = 1'b0;
      w();
      scl = 1'b1;
      w();
      sda_m = 1'b1;
      w();
   endtask
   task automatic xfer(input logic [7:0] tx, input logic m, output logic [7:0] rx, output logic ack);
      logic [8:0] s;
      logic [8:0] r;
      s = {tx, m};
      for (int i = 8; i >= 0; i--) begin
         sda_m = s[i];
         w();
         scl = 1'b1;
         w();
         r[i] = sda;
         w();
         scl = 1'b0;
         w();
      end
      rx = r[8:1];
      ack = r[0];
   endtask
endmodule // cgscp_master

// ### test/testbench.sv
// Purpose: Self-checking bench for the config port.
// Assumes: Straps held at 4'h8.
// Notes: One task per scenario.
`timescale 1ns/1ps
module testbench;
   logic clock;
   logic resetn;
   logic scl;
   logic sda_m;
   logic sda_out;
   logic sda_oe;
   logic strap_phase;
   logic [6:0] b0_out;
   logic [5:0] b1_out;
   int error_cnt = 0;
   int n_tests = 0;
   wire sda = sda_m & (sda_oe ? sda_out : 1'b1);
   cgscp_master u_mst (.clock(clock), .sda(sda), .scl(scl), .sda_m(sda_m));
   // The settle count must outlast the two-stage strap synchroniser, or the reset level is latched.
   cgscp_port #(.STRAP_SETTLE_CYC(4)) u_dut (.clock(clock), .resetn(resetn), .scl_in(scl), .sda_in(sda),
      .sda_out(sda_out), .sda_oe(sda_oe), .strap_freq_code(4'h8), .strap_phase(strap_phase),
      .freq_code(b0_out[6:2]), .spread_enable(b0_out[1]), .outputs_tristate(b0_out[0]),
      .memory_drive_normal(b1_out[5]), .host_pushpull_drive_normal(b1_out[4]),
      .host_diff_drive_normal(b1_out[3]), .memory_clock_free_run_enable(b1_out[2]),
      .host_diff_clock_enable(b1_out[1]), .host_pushpull_clock_enable(b1_out[0]));
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      n_tests++;
      if (got !== exp) begin
         error_cnt++;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic give_verdict();
      $display("checks %0d errors %0d", n_tests, error_cnt);
      if (error_cnt == 0 && n_tests > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   task automatic t_reset();
      chk({1'b0, b0_out}, 8'h22);
      chk({2'b00, b1_out}, 8'h3f);
      chk({7'h00, strap_phase}, 8'h00);
      $display("reset test done");
   endtask
   task automatic t_foreign();
      logic [7:0] rx;
      logic ack;
      u_mst.start();
      u_mst.xfer(8'ha0, 1'b1, rx, ack);
      chk({7'h00, ack}, 8'h01);
      u_mst.stop();
      $display("foreign test done");
   endtask
   task automatic t_write();
      logic [7:0] tx [5] = '{8'hd2, 8'h00, 8'h02, 8'h9d, 8'h24};
      logic [7:0] rx;
      logic ack;
      u_mst.start();
      for (int i = 0; i < 5; i++) begin
         u_mst.xfer(tx[i], 1'b1, rx, ack);
         chk({rx[6:0], ack}, {tx[i][6:0], 1'b0});
      end
      u_mst.stop();
      chk({1'b0, b0_out}, 8'h65);
      chk({2'b00, b1_out}, 8'h10);
      $display("write test done");
   endtask
   task automatic t_read();
      logic [7:0] exp [3] = '{8'h09, 8'h9d, 8'h24};
      logic [7:0] rx;
      logic ack;
      u_mst.start();
      u_mst.xfer(8'hd3, 1'b1, rx, ack);
      chk({7'h00, ack}, 8'h00);
      for (int i = 0; i < 3; i++) begin
         u_mst.xfer(8'hff, i == 2, rx, ack);
         chk(rx, exp[i]);
      end
      chk({7'h00, sda_oe}, 8'h00);
      u_mst.stop();
      $display("read test done");
   endtask
   initial begin
      clock = 1'b0;
      forever #5 clock = ~clock;
   end
   initial begin
      resetn = 1'b0;
      repeat (4) @(posedge clock);
      #1;
      resetn = 1'b1;
      repeat (10) @(posedge clock);
      #1;
      t_reset();
      t_foreign();
      t_write();
      t_read();
      give_verdict();
   end
   initial begin
      repeat (99000) @(posedge clock);
      error_cnt++;
      $display("[ERR] %0t run hung", $time);
      give_verdict();
   end
endmodule // testbench
